// ==== token_ring_status_flags_tb.sv ====
// self-checking bench for the node status flags, host model on the i/o port
// assumes the checker is bound to the design by its own file
`timescale 1ns/1ps
`default_nettype none
module token_ring_status_flags_tb;
  logic       mclk;
  logic       rst;
  logic       pin;
  logic       bcast;
  logic       busy;
  logic [6:0] ev;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr;
  logic       rd;
  logic       host_interrupt;
  logic       rx_en;
  logic [1:0] rpage;
  logic       rbc;
  logic [1:0] tpage;
  logic       lng;
  logic [7:0] nid;
  int         miscompares;
  int         n_checks;
  // ev: token, stored, idle, done, acked, token timer, other token
  trs_host_model host_u (.i_mclk(mclk), .i_io_rdata(rdata), .o_io_addr(addr),
    .o_io_wdata(wdata), .o_io_wr(wr), .o_io_rd(rd));
  trs_node_status dut_u (.i_mclk(mclk), .i_sys_rst(rst), .i_io_addr(addr),
    .i_io_wdata(wdata), .i_io_wr(wr), .i_io_rd(rd), .o_io_rdata(rdata),
    .i_line_receive_input(pin), .i_token_rx(ev[0]), .i_rx_busy(busy),
    .i_rx_packet_stored(ev[1]), .i_line_idle_timeout(ev[2]), .i_tx_done(ev[3]),
    .i_tx_acked(ev[4]), .i_tx_broadcast(bcast), .i_token_timer_expired(ev[5]),
    .i_other_token_seen(ev[6]), .o_host_interrupt(host_interrupt), .o_rx_enable(rx_en),
    .o_rx_page(rpage), .o_rx_broadcast(rbc), .o_tx_start(), .o_tx_page(tpage),
    .o_long_packets(lng), .o_node_id(nid));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    host_u.rd(a, d);
    check(what, exp, d);
  endtask
  task automatic chk_int(input logic exp);
    @(posedge mclk);
    #1 check("interrupt", {7'h00, exp}, {7'h00, host_interrupt});
  endtask
  task automatic pulse(input int b);
    @(posedge mclk);
    ev[b] <= 1'b1;
    @(posedge mclk);
    ev <= 7'h00;
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // the whole sequence needs about 130 cycles
  initial
  begin
    repeat (3000) @(posedge mclk);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    rst = 1'b1;
    pin = 1'b0;
    bcast = 1'b0;
    busy = 1'b0;
    ev = 7'h00;
    miscompares = 0;
    n_checks = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdchk(4'h0, 8'h91, "status");
    rdchk(4'h1, 8'h00, "diag");
    rdchk(4'h6, 8'h00, "unmapped");
    host_u.wr(4'h0, 8'h85);
    chk_int(1'b1);
    host_u.wr(4'h0, 8'h00);
    chk_int(1'b0);
    host_u.wr(4'h1, 8'h0E);
    rdchk(4'h0, 8'h81, "status");
    host_u.wr(4'h0, 8'h04);
    pulse(2);
    rdchk(4'h0, 8'h85, "status");
    chk_int(1'b1);
    rdchk(4'h1, 8'h00, "diag");
    host_u.wr(4'h1, 8'h0E);
    rdchk(4'h0, 8'h85, "status");
    host_u.wr(4'h1, 8'h16);
    rdchk(4'h0, 8'h81, "status");
    chk_int(1'b0);
    host_u.wr(4'h1, 8'h0D);
    host_u.wr(4'h5, 8'h2A);
    rdchk(4'h5, 8'h2A, "node id");
    check("node id out", 8'h2A, nid);
    check("long packets", 8'h01, {7'h00, lng});
    rdchk(4'h0, 8'h81, "status");
    host_u.wr(4'h5, 8'h00);
    rdchk(4'h0, 8'h91, "status");
    host_u.wr(4'h1, 8'h0E);
    host_u.wr(4'h1, 8'h04);
    rdchk(4'h0, 8'h01, "status");
    check("rx enable", 8'h01, {7'h00, rx_en});
    pulse(1);
    rdchk(4'h0, 8'h81, "status");
    check("rx enable", 8'h00, {7'h00, rx_en});
    host_u.wr(4'h1, 8'h9C);
    busy <= 1'b1;
    host_u.wr(4'h1, 8'h02);
    pulse(0);
    rdchk(4'h0, 8'h01, "status");
    check("rx page", 8'h07, {5'h00, rbc, rpage});
    busy <= 1'b0;
    pulse(0);
    rdchk(4'h0, 8'h81, "status");
    check("rx enable", 8'h00, {7'h00, rx_en});
    host_u.wr(4'h1, 8'h03);
    ev[0] <= 1'b1;
    @(posedge mclk);
    ev <= 7'h00;
    rdchk(4'h0, 8'h80, "status");
    pulse(4);
    pulse(3);
    rdchk(4'h0, 8'h83, "status");
    bcast <= 1'b1;
    host_u.wr(4'h1, 8'h03);
    rdchk(4'h0, 8'h80, "status");
    pulse(0);
    pulse(4);
    pulse(3);
    rdchk(4'h0, 8'h81, "status");
    bcast <= 1'b0;
    host_u.wr(4'h1, 8'h1B);
    host_u.wr(4'h1, 8'h01);
    pulse(0);
    rdchk(4'h0, 8'h81, "status");
    check("tx page", 8'h03, {6'h00, tpage});
    pin <= 1'b1;
    pulse(5);
    pulse(6);
    repeat (10) @(posedge mclk);
    rdchk(4'h1, 8'hB0, "diag");
    rdchk(4'h1, 8'h00, "diag");
    host_u.wr(4'h0, 8'h85);
    host_u.wr(4'h8, 8'h00);
    chk_int(1'b0);
    rdchk(4'h0, 8'h91, "status");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdchk(4'h0, 8'h91, "status");
    end_of_test();
  end
endmodule // token_ring_status_flags_tb
`default_nettype wire

// ==== trs_cmd_decode.sv ====
// command decoder: turns a command-location write into one-cycle pulses
// assumes the write strobe is already qualified by address
`timescale 1ns/1ps
`default_nettype none
module trs_cmd_decode (
  input  wire logic                       i_cmd_we,
  input  wire logic [trs_pkg::DATA_W-1:0] i_cmd_data,
  trs_cmd_if.dec                          cmd
);
  logic [2:0] op;
  logic       hi_zero;

  always_comb
  begin
    op            = i_cmd_data[2:0];
    hi_zero       = (i_cmd_data[7:5] == 3'h0);
    // codes outside the set are ignored; the host must not send them
    cmd.dis_tx    = i_cmd_we && (i_cmd_data == trs_pkg::CMD_DIS_TX);
    cmd.dis_rx    = i_cmd_we && (i_cmd_data == trs_pkg::CMD_DIS_RX);
    cmd.en_tx     = i_cmd_we && hi_zero && (op == trs_pkg::OP_EN_TX);
    cmd.en_rx     = i_cmd_we && (i_cmd_data[6:5] == 2'h0) && (op == trs_pkg::OP_EN_RX);
    cmd.def_cfg   = i_cmd_we && (i_cmd_data[7:4] == 4'h0) && (op == trs_pkg::OP_DEF_CFG);
    cmd.clr_flags = i_cmd_we && hi_zero && (op == trs_pkg::OP_CLR_FLG);
    cmd.page      = i_cmd_data[trs_pkg::CMD_PAGE_LSB +: trs_pkg::PAGE_W];
    cmd.bcast     = i_cmd_data[trs_pkg::CMD_BCAST_BIT];
    cmd.long_pkt  = i_cmd_data[trs_pkg::CMD_LONG_BIT];
    cmd.clr_por   = cmd.clr_flags && i_cmd_data[trs_pkg::CMD_POR_BIT];
    cmd.clr_reconfiguration_flag = cmd.clr_flags && i_cmd_data[trs_pkg::CMD_RECONFIGURATION_FLAG_BIT];
  end
endmodule // trs_cmd_decode
`default_nettype wire

// ==== trs_cmd_if.sv ====
// decoded command pulses from the command decoder to the flag core
// assumes all signals are on the single device clock
`timescale 1ns/1ps
`default_nettype none
interface trs_cmd_if;
  logic                       dis_tx;
  logic                       dis_rx;
  logic                       en_tx;
  logic                       en_rx;
  logic                       def_cfg;
  logic                       clr_flags;
  logic [trs_pkg::PAGE_W-1:0] page;
  logic                       bcast;
  logic                       long_pkt;
  logic                       clr_por;
  logic                       clr_reconfiguration_flag;
  modport dec  (output dis_tx, dis_rx, en_tx, en_rx, def_cfg, clr_flags, page, bcast,
                long_pkt, clr_por, clr_reconfiguration_flag);
  modport core (input dis_tx, dis_rx, en_tx, en_rx, def_cfg, clr_flags, page, bcast,
                long_pkt, clr_por, clr_reconfiguration_flag);
endinterface
`default_nettype wire

// ==== trs_host_model.sv ====
// host processor model issuing i/o reads and writes on the register port
// assumes the device samples its strobes on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module trs_host_model (
  input  wire logic                       i_mclk,
  input  wire logic [trs_pkg::DATA_W-1:0] i_io_rdata,
  output logic      [trs_pkg::ADDR_W-1:0] o_io_addr,
  output logic      [trs_pkg::DATA_W-1:0] o_io_wdata,
  output logic                            o_io_wr,
  output logic                            o_io_rd
);
  initial
  begin
    o_io_addr  = 4'h0;
    o_io_wdata = 8'h00;
    o_io_wr    = 1'b0;
    o_io_rd    = 1'b0;
  end
  // callers hand over only defined command codes
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_io_addr  <= a;
    o_io_wdata <= d;
    o_io_wr    <= 1'b1;
    @(posedge i_mclk);
    o_io_wr    <= 1'b0;
    // released data no longer shows the last value
    o_io_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_io_addr <= a;
    o_io_rd   <= 1'b1;
    @(posedge i_mclk);
    o_io_rd   <= 1'b0;
    #1 d = i_io_rdata;
  endtask
endmodule // trs_host_model
`default_nettype wire

// ==== trs_node_status.sv ====
// node status and diagnostic flags with command side effects and interrupt
// assumes transmit/receive engines and timers on the same clock give pulses
`timescale 1ns/1ps
`default_nettype none
module trs_node_status (
  input  wire logic                        i_mclk,
  input  wire logic                        i_sys_rst,
  input  wire logic [trs_pkg::ADDR_W-1:0]  i_io_addr,
  input  wire logic [trs_pkg::DATA_W-1:0]  i_io_wdata,
  input  wire logic                        i_io_wr,
  input  wire logic                        i_io_rd,
  output logic      [trs_pkg::DATA_W-1:0]  o_io_rdata,
  input  wire logic                        i_line_receive_input,
  input  wire logic                        i_token_rx,
  input  wire logic                        i_rx_busy,
  input  wire logic                        i_rx_packet_stored,
  input  wire logic                        i_line_idle_timeout,
  input  wire logic                        i_tx_done,
  input  wire logic                        i_tx_acked,
  input  wire logic                        i_tx_broadcast,
  input  wire logic                        i_token_timer_expired,
  input  wire logic                        i_other_token_seen,
  output logic                             o_host_interrupt,
  output logic                             o_rx_enable,
  output logic      [trs_pkg::PAGE_W-1:0]  o_rx_page,
  output logic                             o_rx_broadcast,
  output logic                             o_tx_start,
  output logic      [trs_pkg::PAGE_W-1:0]  o_tx_page,
  output logic                             o_long_packets,
  output logic      [trs_pkg::DATA_W-1:0]  o_node_id
);
  trs_cmd_if cmd ();

  logic wr_mask;
  logic cmd_we;
  logic wr_nid;
  logic sw_rst;
  logic rd_diag;
  logic rx_transition;
  logic rx_stored;

  logic [trs_pkg::DATA_W-1:0] st_q, st_d;
  logic [trs_pkg::DATA_W-1:0] mask_q, mask_d;
  logic [trs_pkg::DATA_W-1:0] dg_q, dg_d;
  logic [trs_pkg::DATA_W-1:0] nid_q, nid_d;
  logic [trs_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic                       irq_q, irq_d;
  logic                       rx_en_q, rx_en_d;
  logic                       rx_dis_pend_q, rx_dis_pend_d;
  logic [trs_pkg::PAGE_W-1:0] rx_page_q, rx_page_d;
  logic                       rx_bcast_q, rx_bcast_d;
  logic                       long_q, long_d;
  trs_pkg::trs_tx_state_t     tx_state_q, tx_state_d;
  logic                       tx_dis_pend_q, tx_dis_pend_d;
  logic [trs_pkg::PAGE_W-1:0] tx_page_q, tx_page_d;
  logic                       tx_start_q, tx_start_d;

  trs_cmd_decode u_cmd_decode (
    .i_cmd_we   (cmd_we),
    .i_cmd_data (i_io_wdata),
    .cmd        (cmd.dec)
  );

  trs_rx_activity u_rx_activity (
    .i_mclk               (i_mclk),
    .i_sys_rst            (i_sys_rst),
    .i_line_receive_input (i_line_receive_input),
    .o_transition         (rx_transition)
  );

  // address decode
  always_comb
  begin
    wr_mask = 1'b0;
    cmd_we  = 1'b0;
    wr_nid  = 1'b0;
    sw_rst  = 1'b0;
    rd_diag = i_io_rd && (i_io_addr == trs_pkg::OFS_DIAG_CMD);
    if (!i_io_wr)
    begin
      wr_mask = 1'b0;
    end
    else if (i_io_addr == trs_pkg::OFS_STATUS_MASK)
    begin
      wr_mask = 1'b1;
    end
    else if (i_io_addr == trs_pkg::OFS_DIAG_CMD)
    begin
      cmd_we = 1'b1;
    end
    else if (i_io_addr == trs_pkg::OFS_NODE_ID)
    begin
      wr_nid = 1'b1;
    end
    else if ((i_io_addr >= trs_pkg::OFS_RESET_LO) && (i_io_addr <= trs_pkg::OFS_RESET_HI))
    begin
      sw_rst = 1'b1;
    end
  end

  // a packet only counts while the receiver is enabled
  assign rx_stored = i_rx_packet_stored && rx_en_q;

  // status, receive and transmit control; clears first so sets win, but transmit-enable clears TA and TMA after their sets
  always_comb
  begin
    st_d          = st_q;
    mask_d        = mask_q;
    nid_d         = nid_q;
    rx_en_d       = rx_en_q;
    rx_dis_pend_d = rx_dis_pend_q;
    rx_page_d     = rx_page_q;
    rx_bcast_d    = rx_bcast_q;
    long_d        = long_q;
    tx_state_d    = tx_state_q;
    tx_dis_pend_d = tx_dis_pend_q;
    tx_page_d     = tx_page_q;
    tx_start_d    = 1'b0;

    if (wr_mask)
    begin
      mask_d = i_io_wdata & trs_pkg::MASK_DEF;
    end
    if (wr_nid)
    begin
      nid_d = i_io_wdata;
    end
    if (cmd.def_cfg)
    begin
      long_d = cmd.long_pkt;
    end
    // receive side
    if (cmd.en_rx)
    begin
      st_d[trs_pkg::ST_RI] = 1'b0;
      rx_en_d              = 1'b1;
      rx_dis_pend_d        = 1'b0;
      rx_page_d            = cmd.page;
      rx_bcast_d           = cmd.bcast;
    end
    if (cmd.dis_rx && rx_en_q)
    begin
      rx_dis_pend_d = 1'b1;
    end
    // a reception already underway runs to its end
    if (rx_dis_pend_q && i_token_rx && !i_rx_busy)
    begin
      st_d[trs_pkg::ST_RI] = 1'b1;
      rx_en_d              = 1'b0;
      rx_dis_pend_d        = 1'b0;
    end
    if (rx_stored)
    begin
      st_d[trs_pkg::ST_RI] = 1'b1;
      rx_en_d              = 1'b0;
      rx_dis_pend_d        = 1'b0;
    end
    // transmit side
    case (tx_state_q)
      trs_pkg::TRS_TX_ARMED:
      begin
        if (cmd.dis_tx)
        begin
          tx_state_d = trs_pkg::TRS_TX_IDLE;
        end
        else if (i_token_rx)
        begin
          tx_state_d = trs_pkg::TRS_TX_SENDING;
          tx_start_d = 1'b1;
        end
      end
      trs_pkg::TRS_TX_SENDING:
      begin
        if (i_tx_acked && !i_tx_broadcast)
        begin
          st_d[trs_pkg::ST_TMA] = 1'b1;
        end
        if (i_tx_done)
        begin
          st_d[trs_pkg::ST_TA] = 1'b1;
          tx_state_d           = trs_pkg::TRS_TX_IDLE;
        end
      end
      default:
      begin
        tx_state_d = trs_pkg::TRS_TX_IDLE;
      end
    endcase
    if (cmd.dis_tx)
    begin
      tx_dis_pend_d = 1'b1;
    end
    // disable takes effect at the next token
    if (tx_dis_pend_q && i_token_rx)
    begin
      st_d[trs_pkg::ST_TA] = 1'b1;
      tx_dis_pend_d        = 1'b0;
    end
    if (cmd.en_tx)
    begin
      st_d[trs_pkg::ST_TA]  = 1'b0;
      st_d[trs_pkg::ST_TMA] = 1'b0;
      tx_state_d            = trs_pkg::TRS_TX_ARMED;
      tx_page_d             = cmd.page;
      tx_dis_pend_d         = 1'b0;
    end
    // flag clearing, then network events
    if (cmd.clr_por)
    begin
      st_d[trs_pkg::ST_POR] = 1'b0;
    end
    if (cmd.clr_reconfiguration_flag)
    begin
      st_d[trs_pkg::ST_RECONFIGURATION_FLAG] = 1'b0;
    end
    if (i_line_idle_timeout)
    begin
      st_d[trs_pkg::ST_RECONFIGURATION_FLAG] = 1'b1;
    end
    if (wr_nid && (i_io_wdata == trs_pkg::NODE_ID_ZERO))
    begin
      st_d[trs_pkg::ST_POR] = 1'b1;
    end

    // software reset restores status, mask, diagnostic and control state, but not node id, pages, receive broadcast or long-packet mode
    if (sw_rst)
    begin
      st_d          = trs_pkg::STATUS_RST;
      mask_d        = trs_pkg::MASK_RST;
      rx_en_d       = 1'b0;
      rx_dis_pend_d = 1'b0;
      tx_state_d    = trs_pkg::TRS_TX_IDLE;
      tx_dis_pend_d = 1'b0;
      tx_start_d    = 1'b0;
    end
    // undefined and test bits are never stored, so they read zero
    st_d  = st_d & trs_pkg::STATUS_DEF;
    irq_d = |(st_d & mask_d & trs_pkg::MASK_DEF);
  end

  // diagnostic flags and read data
  always_comb
  begin
    dg_d    = dg_q;
    rdata_d = rdata_q;
    if (rd_diag || sw_rst)
    begin
      dg_d = trs_pkg::DIAG_RST;
    end
    // events after the clear so a same-cycle event survives the read
    if (i_token_timer_expired)
    begin
      dg_d[trs_pkg::DG_SELF_CAUSED_RECONFIG] = 1'b1;
    end
    if (rx_transition)
    begin
      dg_d[trs_pkg::DG_RECEIVE_ACTIVITY] = 1'b1;
    end
    if (i_other_token_seen)
    begin
      dg_d[trs_pkg::DG_TOKEN] = 1'b1;
    end
    if (sw_rst)
    begin
      dg_d = trs_pkg::DIAG_RST;
    end
    dg_d = dg_d & trs_pkg::DIAG_DEF;
    if (i_io_rd)
    begin
      if (i_io_addr == trs_pkg::OFS_STATUS_MASK)
      begin
        rdata_d = st_q;
      end
      else if (i_io_addr == trs_pkg::OFS_DIAG_CMD)
      begin
        rdata_d = dg_q;
      end
      else if (i_io_addr == trs_pkg::OFS_NODE_ID)
      begin
        rdata_d = nid_q;
      end
      else
      begin
        rdata_d = trs_pkg::ZERO_BYTE;
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      st_q          <= trs_pkg::STATUS_RST;
      mask_q        <= trs_pkg::MASK_RST;
      dg_q          <= trs_pkg::DIAG_RST;
      nid_q         <= trs_pkg::NODE_ID_RST;
      rdata_q       <= trs_pkg::ZERO_BYTE;
      irq_q         <= 1'b0;
      rx_en_q       <= 1'b0;
      rx_dis_pend_q <= 1'b0;
      rx_page_q     <= '0;
      rx_bcast_q    <= 1'b0;
      long_q        <= 1'b0;
      tx_state_q    <= trs_pkg::TRS_TX_IDLE;
      tx_dis_pend_q <= 1'b0;
      tx_page_q     <= '0;
      tx_start_q    <= 1'b0;
    end
    else
    begin
      st_q          <= st_d;
      mask_q        <= mask_d;
      dg_q          <= dg_d;
      nid_q         <= nid_d;
      rdata_q       <= rdata_d;
      irq_q         <= irq_d;
      rx_en_q       <= rx_en_d;
      rx_dis_pend_q <= rx_dis_pend_d;
      rx_page_q     <= rx_page_d;
      rx_bcast_q    <= rx_bcast_d;
      long_q        <= long_d;
      tx_state_q    <= tx_state_d;
      tx_dis_pend_q <= tx_dis_pend_d;
      tx_page_q     <= tx_page_d;
      tx_start_q    <= tx_start_d;
    end
  end

  assign o_io_rdata       = rdata_q;
  assign o_host_interrupt = irq_q;
  assign o_rx_enable      = rx_en_q;
  assign o_rx_page        = rx_page_q;
  assign o_rx_broadcast   = rx_bcast_q;
  assign o_tx_start       = tx_start_q;
  assign o_tx_page        = tx_page_q;
  assign o_long_packets   = long_q;
  assign o_node_id        = nid_q;
endmodule // trs_node_status
`default_nettype wire

// ==== trs_node_status_monitor.sv ====
// concurrent checks on the node status block ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module trs_node_status_monitor (
  input wire logic                       i_mclk,
  input wire logic                       i_sys_rst,
  input wire logic [trs_pkg::ADDR_W-1:0] i_io_addr,
  input wire logic [trs_pkg::DATA_W-1:0] i_io_wdata,
  input wire logic                       i_io_wr,
  input wire logic                       i_io_rd,
  input wire logic [trs_pkg::DATA_W-1:0] o_io_rdata,
  input wire logic                       i_line_receive_input,
  input wire logic                       i_token_rx,
  input wire logic                       i_rx_packet_stored,
  input wire logic                       i_tx_done,
  input wire logic                       i_tx_acked,
  input wire logic                       i_token_timer_expired,
  input wire logic                       i_other_token_seen,
  input wire logic                       o_host_interrupt,
  input wire logic                       o_rx_enable,
  input wire logic                       o_tx_start
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // the pin passes a synchroniser, so a change shows in the flags some cycles late
  logic       pin_q;
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  logic       calm_rx;
  logic       calm_tx;
  logic       calm_dg;
  assign calm_rx = !i_rx_packet_stored && !i_token_rx && !i_io_wr;
  assign calm_tx = !i_token_rx && !i_tx_acked && !i_tx_done && !i_io_wr;
  assign calm_dg = !i_token_timer_expired && !i_other_token_seen && !i_io_wr;
  always_comb
  begin
    quiet_d = (quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1;
    if (i_line_receive_input != pin_q) quiet_d = 4'h0;
  end
  always_ff @(posedge i_mclk)
  begin
    pin_q   <= i_line_receive_input;
    quiet_q <= i_sys_rst ? 4'h0 : quiet_d;
  end
  sequence s_wr(a, d);
    i_io_wr && i_io_addr == a && i_io_wdata == d;
  endsequence
  sequence s_rd(a);
    i_io_rd && !i_io_wr && i_io_addr == a;
  endsequence
  property p_rx_en;
    s_wr(trs_pkg::OFS_DIAG_CMD, 8'h04) ##1 calm_rx ##1 s_rd(trs_pkg::OFS_STATUS_MASK)
      |=> !o_io_rdata[trs_pkg::ST_RI];
  endproperty
  a_rx_en: assert property (p_rx_en) else $error("receive enable left inhibit set");
  property p_rx_stop;
    o_rx_enable && i_rx_packet_stored && !i_io_wr |=> !o_rx_enable;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("receiver still armed");
  property p_tx_clr;
    s_wr(trs_pkg::OFS_DIAG_CMD, 8'h03) ##1 calm_tx ##1 s_rd(trs_pkg::OFS_STATUS_MASK)
      |=> o_io_rdata[1:0] == 2'h0;
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("transmit flags not cleared");
  property p_tx_go;
    s_wr(trs_pkg::OFS_DIAG_CMD, 8'h03) ##1 (i_token_rx && !i_io_wr) |=> o_tx_start;
  endproperty
  a_tx_go: assert property (p_tx_go) else $error("no transmit start on token");
  property p_por_nid;
    s_wr(trs_pkg::OFS_NODE_ID, 8'h00) ##1 !i_io_wr ##1 s_rd(trs_pkg::OFS_STATUS_MASK)
      |=> o_io_rdata[trs_pkg::ST_POR];
  endproperty
  a_por_nid: assert property (p_por_nid) else $error("zero node id left reset flag low");
  property p_diag_clr;
    s_rd(trs_pkg::OFS_DIAG_CMD) ##0 (calm_dg && quiet_q > 4'h8) ##1 calm_dg
      ##1 s_rd(trs_pkg::OFS_DIAG_CMD) |=> o_io_rdata == 8'h00;
  endproperty
  a_diag_clr: assert property (p_diag_clr) else $error("diagnostic bits kept after read");
  property p_diag_undef;
    s_rd(trs_pkg::OFS_DIAG_CMD) |=> !o_io_rdata[6] && o_io_rdata[3:0] == 4'h0;
  endproperty
  a_diag_undef: assert property (p_diag_undef) else $error("undefined diag bit set");
  property p_stat_undef;
    s_rd(trs_pkg::OFS_STATUS_MASK) |=> o_io_rdata[6:5] == 2'h0 ##0 !o_io_rdata[3];
  endproperty
  a_stat_undef: assert property (p_stat_undef) else $error("undefined status bit set");
  property p_mask0;
    s_wr(trs_pkg::OFS_STATUS_MASK, 8'h00) ##1 !i_io_wr |=> !o_host_interrupt;
  endproperty
  a_mask0: assert property (p_mask0) else $error("interrupt with all masked");
  property p_swrst;
    i_io_wr && i_io_addr == trs_pkg::OFS_RESET_LO ##1 !i_io_wr |=> !o_host_interrupt;
  endproperty
  a_swrst: assert property (p_swrst) else $error("interrupt after software reset");
  property p_hwrst;
    $fell(i_sys_rst) |-> !o_host_interrupt && !o_rx_enable && !o_tx_start;
  endproperty
  a_hwrst: assert property (p_hwrst) else $error("outputs active after reset");
endmodule // trs_node_status_monitor
bind trs_node_status trs_node_status_monitor mon_u (.i_mclk, .i_sys_rst, .i_io_addr,
  .i_io_wdata, .i_io_wr, .i_io_rd, .o_io_rdata, .i_line_receive_input, .i_token_rx,
  .i_rx_packet_stored, .i_tx_done, .i_tx_acked, .i_token_timer_expired,
  .i_other_token_seen, .o_host_interrupt, .o_rx_enable, .o_tx_start);
`default_nettype wire

// ==== trs_pkg.sv ====
// constants shared by the node status flag block and its helpers
// assumes one 250 MHz clock and a synchronous active-high reset
// How it works
// - status bit 7 sets when a packet lands in the enabled page; receiver stops
// - no packet is accepted before a receive-enable command
// - receive-enable command clears the receiver-inhibited bit
// - inhibited, reconfig and transmitter-available bits interrupt when their mask is set
// - status bits 6 and 5 have no meaning
// - reset indication sets on hardware or software reset or node id zero
// - only the flag-clearing command clears reset indication
// - status bit 3 is a test bit reading zero normally
// - reconfiguration bit sets when the line idle timer expires
// - flag-clearing command clears the reconfiguration bit
// - transmit-acknowledged sets when the transmitted packet is acknowledged
// - broadcast packets never set transmit-acknowledged
// - transmit-enable command clears transmit-acknowledged
// - transmitter-available sets when transmit ends or transmitter is disabled
// - transmit-enable command clears transmitter-available
// - diagnostic bit 7 sets when the token reception timer expires
// - diagnostic bit 5 sets on a data transition of the receive pin
// - diagnostic bit 4 sets when another node's token is seen
// - diagnostic bits 6 and 3..0 have no meaning
// - defined diagnostic bits clear on diagnostic read and on any reset
// - status reads 1xx1 0001 after any reset
// - interrupt is the OR of the three masked status bits
// - flag-clearing code 000r p110: p clears reset indication, r reconfig
`default_nettype none

package trs_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned PAGE_W = 2;

  // i/o offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS_MASK = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_DIAG_CMD    = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_NODE_ID     = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_RESET_LO    = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_RESET_HI    = 4'hB;

  // status bit positions
  localparam int unsigned ST_RI    = 7;
  localparam int unsigned ST_POR   = 4;
  localparam int unsigned ST_RECONFIGURATION_FLAG = 2;
  localparam int unsigned ST_TMA   = 1;
  localparam int unsigned ST_TA    = 0;
  // diagnostic bit positions
  localparam int unsigned DG_SELF_CAUSED_RECONFIG = 7;
  localparam int unsigned DG_RECEIVE_ACTIVITY  = 5;
  localparam int unsigned DG_TOKEN   = 4;

  localparam logic [DATA_W-1:0] STATUS_RST = 8'h91;
  localparam logic [DATA_W-1:0] STATUS_DEF = 8'h97;
  localparam logic [DATA_W-1:0] MASK_RST   = 8'h00;
  localparam logic [DATA_W-1:0] MASK_DEF   = 8'h85;
  localparam logic [DATA_W-1:0] DIAG_RST   = 8'h00;
  localparam logic [DATA_W-1:0] DIAG_DEF   = 8'hB0;
  localparam logic [DATA_W-1:0] NODE_ID_RST = 8'h00;
  localparam logic [DATA_W-1:0] NODE_ID_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;

  // command encodings
  localparam logic [DATA_W-1:0] CMD_DIS_TX  = 8'h01;
  localparam logic [DATA_W-1:0] CMD_DIS_RX  = 8'h02;
  localparam logic [2:0]        OP_EN_TX    = 3'h3;
  localparam logic [2:0]        OP_EN_RX    = 3'h4;
  localparam logic [2:0]        OP_DEF_CFG  = 3'h5;
  localparam logic [2:0]        OP_CLR_FLG  = 3'h6;
  localparam int unsigned CMD_PAGE_LSB  = 3;
  localparam int unsigned CMD_BCAST_BIT = 7;
  localparam int unsigned CMD_LONG_BIT  = 3;
  localparam int unsigned CMD_POR_BIT   = 3;
  localparam int unsigned CMD_RECONFIGURATION_FLAG_BIT = 4;

  typedef enum logic [1:0] {
    TRS_TX_IDLE,
    TRS_TX_ARMED,
    TRS_TX_SENDING
  } trs_tx_state_t;
endpackage
`default_nettype wire

// ==== trs_rx_activity.sv ====
// receive pin synchroniser with transition detector
// assumes the pin is asynchronous to the device clock
`timescale 1ns/1ps
`default_nettype none
module trs_rx_activity (
  input  wire logic i_mclk,
  input  wire logic i_sys_rst,
  input  wire logic i_line_receive_input,
  output logic      o_transition
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       level_q;
  logic       level_d;

  always_comb
  begin
    sync_d       = {sync_q[1:0], i_line_receive_input};
    level_d      = level_q;
    o_transition = 1'b0;
    // first stage stays unread so metastability cannot leak
    if ((sync_q[1] == sync_q[2]) && (sync_q[2] != level_q))
    begin
      level_d      = sync_q[2];
      o_transition = 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
    end
    else
    begin
      sync_q  <= sync_d;
      level_q <= level_d;
    end
  end
endmodule // trs_rx_activity
`default_nettype wire
